// ### logic/sisp_top.sv
// Serial in-system programming slave: link, instruction executor, arrays.
// Notes on behaviour
// - Programming only while reset pin held low.
// - Nothing executes before programming enable.
// - EEPROM write erases its byte itself.
// - Chip erase fills flash and EEPROM with 0xFF.
// - MOSI sampled on SCK rising edge.
// - MISO changes on SCK falling edge.
// - Second enable byte echoes during third.
// - Page buffer loads one byte per instruction.
// - Page write uses seven page bits.
// - EEPROM written one byte per instruction.
// - Read returns addressed location on MISO.
// - Reset pin high leaves programming mode.
// - Busy page reads 0xFF until written.
// - Enable is 0xAC 0x53 then two bytes.
// - Busy EEPROM byte reads 0xFF meanwhile.
`timescale 1ns/1ps
`default_nettype none
module sisp_top import sisp_pkg::*; #(
  parameter int FLASH_WAIT = FLASH_WAIT_CYC,
  parameter int EE_WAIT = EE_WAIT_CYC,
  parameter int ERASE_WAIT = ERASE_WAIT_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic SCK,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  output logic PROG_EN,
  output logic BUSY
);
  if (FLASH_WAIT < 1 || EE_WAIT < 1 || ERASE_WAIT < 1 ||
      FLASH_WAIT >= (1 << TMR_W) || EE_WAIT >= (1 << TMR_W) ||
      ERASE_WAIT >= (1 << TMR_W)) begin : g_chk
    $error("sisp_top: wait counts out of timer range");
  end

  // Two-stage synchronisers; the third SCK stage only feeds edge detection.
  logic [1:0] rstn_q, mosi_q;
  logic [2:0] sck_q;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rstn_q <= 2'h3;
      mosi_q <= 2'h0;
      sck_q <= 3'h0;
    end else begin
      rstn_q <= {rstn_q[0], RESET_N};
      mosi_q <= {mosi_q[0], MOSI};
      sck_q <= {sck_q[1:0], SCK};
    end
  end

  logic link_on, sck_rise, sck_fall;
  assign link_on = !rstn_q[1];
  assign sck_rise = link_on && sck_q[1] && !sck_q[2];
  assign sck_fall = link_on && !sck_q[1] && sck_q[2];

  // Executor state, declared early because the link reads it.
  sisp_state_t st_r, st_nxt;
  logic en_r, en_nxt, fl_busy_r, fl_busy_nxt, ee_busy_r, ee_busy_nxt;
  logic er_busy_r, er_busy_nxt, busy_r;
  logic [PG_W-1:0] page_r, page_nxt;
  logic [EE_AW-1:0] ee_a_r, ee_a_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic [7:0] fl_rd, ee_rd, pb_rd;

  // Link group: shift registers, byte framing and read selection.
  logic [4:0] bitcnt_r, bitcnt_nxt;
  logic [INSN_W-1:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt, out_byte;
  logic miso_r, miso_nxt, oe_r, first_r, first_nxt;
  logic rd_fl_r, rd_fl_nxt, rd_ee_r, rd_ee_nxt, hit;
  logic [FL_AW-1:0] fl_ra_r, fl_ra_nxt;
  logic [EE_AW-1:0] ee_ra_r, ee_ra_nxt;
  logic in_valid, in_ready;

  // A read of a location still being programmed answers erased data.
  always_comb begin
    hit = er_busy_r ||
      (rd_fl_r && fl_busy_r && fl_ra_r[FL_AW-1:PB_AW] == page_r) ||
      (rd_ee_r && ee_busy_r && ee_ra_r == ee_a_r);
    if (bitcnt_r[4:3] == 2'h3 && (rd_fl_r || rd_ee_r)) begin
      out_byte = hit ? ERASED : (rd_fl_r ? fl_rd : ee_rd);
    end else begin
      out_byte = rx_r[7:0];
    end
  end

  // Bits enter on rising edges, leave on falling edges, MSB first.
  always_comb begin
    bitcnt_nxt = bitcnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    miso_nxt = miso_r;
    first_nxt = first_r;
    rd_fl_nxt = rd_fl_r;
    rd_ee_nxt = rd_ee_r;
    fl_ra_nxt = fl_ra_r;
    ee_ra_nxt = ee_ra_r;
    in_valid = 1'b0;
    if (!link_on) begin
      bitcnt_nxt = BITCNT_RST;
      tx_nxt = TX_RST;
      miso_nxt = 1'b0;
      first_nxt = 1'b0;
      rd_fl_nxt = 1'b0;
      rd_ee_nxt = 1'b0;
    end else if (sck_rise) begin
      rx_nxt = {rx_r[INSN_W-2:0], mosi_q[1]};
      bitcnt_nxt = bitcnt_r + 5'h01;
      first_nxt = bitcnt_r[2:0] == 3'h7;
      if (bitcnt_r == 5'h17) begin
        // Third byte complete: latch the read address ahead of byte four.
        rd_fl_nxt = en_r && (rx_nxt[23:16] & HALF_MASK) == OP_RD_FL;
        rd_ee_nxt = en_r && rx_nxt[23:16] == OP_RD_EE;
        fl_ra_nxt = {rx_nxt[11:8], rx_nxt[7:0], rx_nxt[16+HALF_BIT]};
        ee_ra_nxt = {rx_nxt[8], rx_nxt[7:0]};
      end
      if (bitcnt_r == 5'h1f) begin
        in_valid = 1'b1;
        rd_fl_nxt = 1'b0;
        rd_ee_nxt = 1'b0;
      end
    end else if (sck_fall) begin
      if (first_r) begin
        miso_nxt = out_byte[7];
        tx_nxt = {out_byte[6:0], 1'b0};
        first_nxt = 1'b0;
      end else begin
        miso_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      bitcnt_r <= BITCNT_RST;
      rx_r <= '0;
      tx_r <= TX_RST;
      miso_r <= 1'b0;
      oe_r <= 1'b0;
      first_r <= 1'b0;
      rd_fl_r <= 1'b0;
      rd_ee_r <= 1'b0;
      fl_ra_r <= '0;
      ee_ra_r <= '0;
    end else begin
      bitcnt_r <= bitcnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      miso_r <= miso_nxt;
      oe_r <= link_on;
      first_r <= first_nxt;
      rd_fl_r <= rd_fl_nxt;
      rd_ee_r <= rd_ee_nxt;
      fl_ra_r <= fl_ra_nxt;
      ee_ra_r <= ee_ra_nxt;
    end
  end

  // Whole instructions queue here; a full queue drops the instruction.
  logic f_valid, pop;
  logic [INSN_W-1:0] f_data;
  sisp_fifo #(.W(INSN_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(MCLK),
    .rst(RST),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(rx_nxt),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  // Instruction fields of the queued word.
  logic [7:0] b1, b2, b3, b4;
  assign {b1, b2, b3, b4} = f_data;

  // Array write ports, driven by the executor.
  logic fl_we, ee_we, pb_we;
  logic [FL_AW-1:0] fl_wa;
  logic [EE_AW-1:0] ee_wa;
  logic [PB_AW-1:0] pb_wa;
  logic [7:0] fl_wd, ee_wd, pb_wd;

  // Executor: only idle pops, so queued work waits out a running write.
  assign pop = f_valid && st_r == S_IDLE;

  always_comb begin
    st_nxt = st_r;
    en_nxt = en_r;
    fl_busy_nxt = fl_busy_r;
    ee_busy_nxt = ee_busy_r;
    er_busy_nxt = er_busy_r;
    page_nxt = page_r;
    ee_a_nxt = ee_a_r;
    cnt_nxt = cnt_r;
    tmr_nxt = tmr_r;
    fl_we = 1'b0;
    fl_wa = {page_r, cnt_r[PB_AW-1:0] - 6'h01};
    fl_wd = pb_rd;
    ee_we = 1'b0;
    ee_wa = {b2[0], b3};
    ee_wd = b4;
    pb_we = 1'b0;
    pb_wa = {b3[4:0], b1[HALF_BIT]};
    pb_wd = b4;
    case (st_r)
      S_IDLE: begin
        if (pop) begin
          if (b1 == OP_PGM_EN && b2 == PGM_EN_KEY) begin
            en_nxt = 1'b1;
          end else if (!en_r) begin
            en_nxt = 1'b0;
          end else if (b1 == OP_PGM_EN && b2[7:5] == ERASE_KEY) begin
            st_nxt = S_ERASE;
            er_busy_nxt = 1'b1;
            cnt_nxt = CNT_RST;
          end else if ((b1 & HALF_MASK) == OP_LD_PG) begin
            pb_we = 1'b1;
          end else if (b1 == OP_WR_PG) begin
            st_nxt = S_COPY;
            fl_busy_nxt = 1'b1;
            page_nxt = {b2[3:0], b3[7:5]};
            cnt_nxt = CNT_RST;
          end else if (b1 == OP_WR_EE) begin
            ee_we = 1'b1;
            ee_busy_nxt = 1'b1;
            ee_a_nxt = {b2[0], b3};
            tmr_nxt = TMR_W'(EE_WAIT);
            st_nxt = S_WAIT;
          end
        end
      end
      S_COPY: begin
        // Buffer reads lag one cycle, so byte n is written at count n+1.
        fl_we = cnt_r != CNT_RST;
        cnt_nxt = cnt_r + 14'h0001;
        if (cnt_r == 14'h0040) begin
          tmr_nxt = TMR_W'(FLASH_WAIT);
          st_nxt = S_WAIT;
        end
      end
      S_ERASE: begin
        fl_we = 1'b1;
        fl_wa = cnt_r[FL_AW-1:0];
        fl_wd = ERASED;
        ee_we = cnt_r < 14'h0200;
        ee_wa = cnt_r[EE_AW-1:0];
        ee_wd = ERASED;
        cnt_nxt = cnt_r + 14'h0001;
        if (cnt_r == 14'h1fff) begin
          tmr_nxt = TMR_W'(ERASE_WAIT);
          st_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        tmr_nxt = tmr_r - 21'h000001;
        if (tmr_r == 21'h000001) begin
          st_nxt = S_IDLE;
          fl_busy_nxt = 1'b0;
          ee_busy_nxt = 1'b0;
          er_busy_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
    if (!link_on) begin
      en_nxt = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_r <= S_IDLE;
      en_r <= 1'b0;
      fl_busy_r <= 1'b0;
      ee_busy_r <= 1'b0;
      er_busy_r <= 1'b0;
      page_r <= '0;
      ee_a_r <= '0;
      cnt_r <= CNT_RST;
      tmr_r <= TMR_RST;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      en_r <= en_nxt;
      fl_busy_r <= fl_busy_nxt;
      ee_busy_r <= ee_busy_nxt;
      er_busy_r <= er_busy_nxt;
      page_r <= page_nxt;
      ee_a_r <= ee_a_nxt;
      cnt_r <= cnt_nxt;
      tmr_r <= tmr_nxt;
      busy_r <= st_nxt != S_IDLE;
    end
  end

  // Arrays: flash, EEPROM and the flash page buffer.
  sisp_mem #(.AW(FL_AW), .DW(8)) u_flash (
    .clk(MCLK), .we(fl_we), .wa(fl_wa), .wd(fl_wd),
    .ra(fl_ra_r), .rd(fl_rd)
  );
  sisp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
    .clk(MCLK), .we(ee_we), .wa(ee_wa), .wd(ee_wd),
    .ra(ee_ra_r), .rd(ee_rd)
  );
  sisp_mem #(.AW(PB_AW), .DW(8)) u_pagebuf (
    .clk(MCLK), .we(pb_we), .wa(pb_wa), .wd(pb_wd),
    .ra(cnt_r[PB_AW-1:0]), .rd(pb_rd)
  );

  assign MISO = miso_r;
  assign MISO_OE = oe_r;
  assign PROG_EN = en_r;
  assign BUSY = busy_r;

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  AST_RESET_HIGH_EXITS: assert property (rstn_q[1] |=> !en_r && !oe_r)
    else $error("programming mode held with reset pin high");
  AST_NO_ENABLE_NO_WORK: assert property (pop && !en_r |=> st_r == S_IDLE)
    else $error("work started before programming enable");
  AST_ERASE_FF: assert property (st_r == S_ERASE |-> fl_we && fl_wd == ERASED)
    else $error("chip erase wrote a value other than 0xff");
  AST_RISE_SAMPLE: assert property (sck_rise |=> rx_r[0] == $past(mosi_q[1]))
    else $error("MOSI not sampled on rising edge");
  AST_FALL_SHIFT: assert property ($changed(miso_r) |-> $past(sck_fall) || !$past(link_on))
    else $error("MISO changed away from a falling edge");
  AST_ECHO: assert property (sck_fall && first_r && bitcnt_r == 5'h10 |=> miso_r == $past(rx_r[7]))
    else $error("second byte not echoed during third");
  AST_PAGE_TARGET: assert property (st_r == S_COPY && fl_we |-> fl_wa[FL_AW-1:PB_AW] == page_r)
    else $error("page written to the wrong page");
  AST_BUSY_READS_FF: assert property (sck_fall && first_r && bitcnt_r == 5'h18 && hit && (rd_fl_r || rd_ee_r) |=> miso_r)
    else $error("busy location did not read 0xff");
  AST_EE_SELF_TIMED: assert property (st_r == S_IDLE && ee_we |=> st_r == S_WAIT && ee_busy_r ##1 ee_busy_r)
    else $error("EEPROM write not followed by timed wait");
  AST_COPY_LEN: assert property ($rose(st_r == S_COPY) |-> (st_r == S_COPY) [*8] ##1 st_r == S_COPY)
    else $error("page commit ended early");

  COV_ENABLE: cover property ($rose(en_r));
  COV_PAGE: cover property (st_r == S_COPY ##1 st_r == S_WAIT);
  COV_ERASE: cover property ($rose(st_r == S_ERASE));
  COV_EE: cover property (st_r == S_IDLE && ee_we);
  // A full queue drops the finished instruction; seen only under flooding.
  COV_QUEUE_FULL: cover property (in_valid && !in_ready);
endmodule
`default_nettype wire

// ### logic/sisp_pkg.sv
// Shared constants and types for the serial in-system programming slave.
package sisp_pkg;
  // Core clock and the minimum programming delays, held in microseconds.
  localparam int CLK_MHZ = 125;
  localparam int FLASH_WAIT_US = 4500;
  localparam int EE_WAIT_US = 9000;
  localparam int ERASE_WAIT_US = 9000;
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
  localparam int EE_WAIT_CYC = EE_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  // Array geometry: byte addresses of flash, EEPROM and the page buffer.
  localparam int FL_AW = 13;
  localparam int EE_AW = 9;
  localparam int PB_AW = 6;
  localparam int PG_W = 7;
  localparam int TMR_W = 21;
  localparam int CNT_W = 14;
  localparam int INSN_W = 32;
  localparam int FIFO_DEPTH = 8;
  // Instruction codes; the half-select bit of flash opcodes is bit 3.
  localparam logic [7:0] OP_PGM_EN = 8'hac;
  localparam logic [7:0] PGM_EN_KEY = 8'h53;
  localparam logic [2:0] ERASE_KEY = 3'h4;
  localparam logic [7:0] OP_RD_FL = 8'h20;
  localparam logic [7:0] OP_LD_PG = 8'h40;
  localparam logic [7:0] OP_WR_PG = 8'h4c;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] HALF_MASK = 8'hf7;
  localparam int HALF_BIT = 3;
  localparam logic [7:0] ERASED = 8'hff;
  // Values after reset.
  localparam logic [4:0] BITCNT_RST = 5'h00;
  localparam logic [7:0] TX_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
  localparam logic [TMR_W-1:0] TMR_RST = 21'h000000;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_COPY = 4'b0010,
    S_ERASE = 4'b0100,
    S_WAIT = 4'b1000
  } sisp_state_t;
endpackage

// ### logic/sisp_mem.sv
// Simple dual-port byte memory with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module sisp_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [DW-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [DW-1:0] rd
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_nxt;

  if (AW < 1 || DW < 1) begin : g_chk
    $error("sisp_mem: bad geometry");
  end

  // A blank array reads as erased.
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = '1;
    end
  end

  // Read data is taken from the array before a same-cycle write lands.
  always_comb begin
    rd_nxt = mem[ra];
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd <= rd_nxt;
  end
endmodule
`default_nettype wire

// ### logic/sisp_fifo.sv
// Synchronous valid/ready FIFO with parameter width and depth.
`timescale 1ns/1ps
`default_nettype none
module sisp_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] buf_r [0:DEPTH-1];
  logic [PW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("sisp_fifo: DEPTH must be a power of two");
  end

  // Full when the pointers differ only in the wrap bit.
  always_comb begin
    in_ready = (wp_r ^ rp_r) != {1'b1, {PW{1'b0}}};
    out_valid = wp_r != rp_r;
    out_data = buf_r[rp_r[PW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = wp_r + (PW+1)'(push);
    rp_nxt = rp_r + (PW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push) begin
      buf_r[wp_r[PW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ### sim/sisp_prog_model.sv
// Programmer model that drives the reset pin and the serial link.
`timescale 1ns/1ps
`default_nettype none
module sisp_prog_model #(
  parameter int HALF = 5,
  parameter int START_WAIT = 50
) (
  input wire logic clk,
  input wire logic miso,
  output logic reset_n,
  output logic sck,
  output logic mosi
);
  // Reset pin and SCK sit low from power-up onwards.
  initial begin
    reset_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // Idle time before the first instruction, shortened to keep runs brief.
  task automatic settle();
    repeat (START_WAIT) @(posedge clk);
  endtask

  // Whole instruction, 32 bits MSB first; SCK stands low between frames.
  // Low and high phases of HALF clocks each make an 80 ns period at the
  // default, well clear of the 3-clock minimum.
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk);
      mosi <= w[i];
      repeat (HALF - 1) @(posedge clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      r[i] = miso; // Sampled late in the high phase, long settled.
      sck <= 1'b0;
    end
  endtask

  // Moves the reset pin; a high pulse resynchronises the link.
  task automatic set_reset(input logic v);
    @(posedge clk);
    reset_n <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### sim/serial_isp_programming_tb.sv
// Self-checking bench for the serial in-system programming slave.
`timescale 1ns/1ps
`default_nettype none
module serial_isp_programming_tb;
  import sisp_pkg::*;
  // Short delays; the bench polls BUSY or waits a fixed delay.
  localparam int FW = 2000;
  localparam int EW = 2000;
  localparam int CW = 200;
  logic MCLK;
  logic RST;
  wire logic RESET_N;
  wire logic SCK;
  wire logic MOSI;
  logic MISO;
  logic MISO_OE;
  logic PROG_EN;
  logic BUSY;
  logic miso_last = 1'b0;
  wire logic miso_line;
  logic [31:0] r;
  int n_mismatch = 0;
  int num_checks = 0;

  sisp_top #(.FLASH_WAIT(FW), .EE_WAIT(EW), .ERASE_WAIT(CW)) u_dut (
    .MCLK(MCLK), .RST(RST), .RESET_N(RESET_N), .SCK(SCK), .MOSI(MOSI),
    .MISO(MISO), .MISO_OE(MISO_OE), .PROG_EN(PROG_EN), .BUSY(BUSY)
  );
  sisp_prog_model u_prog (
    .clk(MCLK), .miso(miso_line), .reset_n(RESET_N), .sck(SCK),
    .mosi(MOSI)
  );

  // An undriven MISO shows the inverse of its last level, never a copy.
  assign miso_line = MISO_OE ? MISO : ~miso_last;
  always @(posedge MCLK) begin
    if (MISO_OE === 1'b1) begin
      miso_last <= MISO;
    end
  end

  // Free-running core clock at 125 MHz.
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // Bounded wait for BUSY to drop; a hang ends the run as a failure.
  task automatic wait_idle();
    repeat (8) @(posedge MCLK);
    for (int i = 0; i < 12000; i++) begin
      @(posedge MCLK);
      if (BUSY === 1'b0) begin
        return;
      end
    end
    n_mismatch++;
    $display("MISMATCH t=%0t BUSY never dropped", $time);
    conclude();
  endtask

  // Writes before enable are ignored and the link is live.
  task automatic t_refuse();
    u_prog.xfer(32'hc0001077, r);
    repeat (8) @(posedge MCLK);
    chk_bit(BUSY, 1'b0);
    chk_bit(PROG_EN, 1'b0);
    chk_bit(MISO_OE, 1'b1);
  endtask

  // Enable: bytes two and three echo the one before, 0x53 during byte three.
  task automatic t_enable();
    u_prog.xfer(32'hac530000, r);
    chk_byte(r[23:16], 8'hac);
    chk_byte(r[15:8], PGM_EN_KEY);
    repeat (8) @(posedge MCLK);
    chk_bit(PROG_EN, 1'b1);
    u_prog.xfer(32'ha0001000, r);
    chk_byte(r[7:0], ERASED);
  endtask

  // EEPROM rewrite without erase; busy byte reads 0xff meanwhile.
  task automatic t_eeprom();
    logic [7:0] v [2];
    v = '{8'h5a, 8'ha5};
    for (int k = 0; k < 2; k++) begin
      u_prog.xfer({24'hc00123, v[k]}, r);
      u_prog.xfer(32'ha0012300, r);
      chk_byte(r[7:0], ERASED);
      chk_bit(BUSY, 1'b1);
      wait_idle();
      u_prog.xfer(32'ha0012300, r);
      chk_byte(r[7:0], v[k]);
    end
  endtask

  // Load page 5 low byte first, commit, wait a fixed delay, then read back.
  task automatic t_flash();
    u_prog.xfer(32'h40000012, r);
    u_prog.xfer(32'h48000034, r);
    u_prog.xfer(32'h40000156, r);
    u_prog.xfer(32'h4c00a000, r);
    u_prog.xfer(32'h2000a100, r);
    chk_byte(r[7:0], ERASED);
    // Most of the page stays 0xff, so a fixed wait stands in for polling.
    repeat (FW + 80) @(posedge MCLK);
    chk_bit(BUSY, 1'b0);
    u_prog.xfer(32'h2000a000, r);
    chk_byte(r[7:0], 8'h12);
    u_prog.xfer(32'h2800a000, r);
    chk_byte(r[7:0], 8'h34);
    u_prog.xfer(32'h2000a100, r);
    chk_byte(r[7:0], 8'h56);
    u_prog.xfer(32'h20000000, r);
    chk_byte(r[7:0], ERASED);
  endtask

  // Chip erase returns both arrays to 0xff.
  task automatic t_erase();
    u_prog.xfer(32'hac800000, r);
    repeat (8) @(posedge MCLK);
    chk_bit(BUSY, 1'b1);
    wait_idle();
    u_prog.xfer(32'h2000a000, r);
    chk_byte(r[7:0], ERASED);
    u_prog.xfer(32'ha0012300, r);
    chk_byte(r[7:0], ERASED);
  endtask

  // Reset pin high leaves the mode; re-entry needs a fresh enable.
  task automatic t_exit();
    u_prog.set_reset(1'b1);
    chk_bit(PROG_EN, 1'b0);
    chk_bit(MISO_OE, 1'b0);
    u_prog.set_reset(1'b0);
    u_prog.settle();
    u_prog.xfer(32'hc0001077, r);
    repeat (8) @(posedge MCLK);
    chk_bit(BUSY, 1'b0);
    u_prog.xfer(32'hac530000, r);
    chk_byte(r[15:8], PGM_EN_KEY);
    u_prog.xfer(32'ha0001000, r);
    chk_byte(r[7:0], ERASED);
  endtask

  // Main sequence: reset for 5 clocks, then the scenarios in turn.
  initial begin
    RST = 1'b1;
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    u_prog.settle();
    t_refuse();
    t_enable();
    t_eeprom();
    t_flash();
    t_erase();
    t_exit();
    conclude();
  end
endmodule
`default_nettype wire
